/* File: hdl/oshz_defs.svh */
// Timing counts and field positions for the output shutdown block
`ifndef OSHZ_DEFS_SVH
`define OSHZ_DEFS_SVH
// Level-detect sample dividers, in clock-B cycles
`define OSHZ_DIV8 8
`define OSHZ_DIV16 16
`define OSHZ_DIV128 128
// Consecutive low samples that make a level fault
`define OSHZ_LOW_SAMPLES 16
// Mode select encodings
`define OSHZ_MODE_EDGE 2'h0
`define OSHZ_MODE_D8 2'h1
`define OSHZ_MODE_D16 2'h2
`define OSHZ_MODE_D128 2'h3
// Fault input positions in the five-bit vector
`define OSHZ_IN0 0
`define OSHZ_IN4 1
`define OSHZ_IN8 2
`define OSHZ_IN10 3
`define OSHZ_IN11 4
// Pin groups
`define OSHZ_GRP34 0
`define OSHZ_GRP67 1
`define OSHZ_GRP0 2
`endif

/* File: hdl/oshz_pkg.sv */
// Types shared by the output shutdown block
package oshz_pkg;
  // Six compared complementary pairs, first three in the ch3/4 group
  typedef struct packed {
    logic [5:0] hi;
    logic [5:0] lo;
  } oshz_pairs_type;
  // Software control, held by the system as plain levels and pulses
  typedef struct packed {
    logic [4:0][1:0] mode;
    logic [2:0] add_in4;
    logic [2:0] add_in8;
    logic [2:0] add_in0;
    logic [2:0] add_in10;
    logic [2:0] add_in11;
    logic [2:0] cmp_en;
    logic [2:0] soft_hiz;
    logic [2:0] osc_en;
    logic [4:0] clr_in;
    logic [1:0] clr_cmp;
    logic [2:0] clr_osc;
  } oshz_ctrl_type;
  // Per-input detector state
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [6:0] pre;
    logic [4:0] cnt;
    logic flag;
  } oshz_det_type;
  typedef struct packed {
    logic [4:0] in_flag;
    logic [1:0] cmp_flag;
    logic [2:0] osc_hiz;
    logic [2:0] hiz;
    logic [1:0] pin_sel0;
    logic pin_sel3;
    logic [1:0] pin_sel4;
    logic irq;
  } oshz_state_type;
endpackage : oshz_pkg

/* File: hdl/oshz_fault_det.sv */
// One active-low fault input: synchroniser, edge and level detection
`include "oshz_defs.svh"
module oshz_fault_det (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Fault pin and control
  input wire logic fault_n_i,
  input wire logic [1:0] mode_i,
  input wire logic clr_i,
  // Sticky request
  output logic flag_o
);
  oshz_pkg::oshz_det_type st, next_st;
  logic tick;
  logic hit;
  always_comb
  begin
    next_st = st;
    next_st.s1 = fault_n_i;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    next_st.pre = st.pre + 7'h01;
    case (mode_i)
      `OSHZ_MODE_D8: tick = (st.pre[2:0] == 3'(`OSHZ_DIV8 - 1));
      `OSHZ_MODE_D16: tick = (st.pre[3:0] == 4'(`OSHZ_DIV16 - 1));
      `OSHZ_MODE_D128: tick = (st.pre == 7'(`OSHZ_DIV128 - 1));
      default: tick = 1'b0;
    endcase
    hit = 1'b0;
    if (mode_i == `OSHZ_MODE_EDGE)
    begin
      hit = st.prev && !st.s2;
      next_st.cnt = 5'h00;
    end
    else if (st.s2)
    begin
      next_st.cnt = 5'h00;
    end
    else if (tick)
    begin
      // Saturate so a held low does not wrap and re-arm
      if (st.cnt != 5'(`OSHZ_LOW_SAMPLES))
      begin
        next_st.cnt = st.cnt + 5'h01;
      end
      hit = (st.cnt == 5'(`OSHZ_LOW_SAMPLES - 1));
    end
    // Set wins over clear
    next_st.flag = hit || (st.flag && !clr_i);
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.s1 <= 1'b1;
      st.s2 <= 1'b1;
      st.prev <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end
  assign flag_o = st.flag;
endmodule // oshz_fault_det

/* File: hdl/oshz_pin_gate.sv */
// Routes one timer output onto one of two ports, with high-impedance forcing
module oshz_pin_gate (
  // Timer side
  input wire logic out_i,
  input wire logic oe_n_i,
  // Control
  input wire logic sel_i,
  input wire logic hiz_i,
  // Port side, two candidate ports
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe_n_o
);
  // Forcing overrides any function on the port, timer or not
  always_comb
  begin
    pin_o = {out_i, out_i};
    pin_oe_n_o = 2'h3;
    if (!hiz_i && !oe_n_i)
    begin
      pin_oe_n_o[sel_i] = 1'b0;
    end
  end
endmodule // oshz_pin_gate

/* File: hdl/oshz_top.sv */
// Output shutdown (high-impedance) controller for timer output pins
// How it works
// - All detection and sampling runs on the one clock, mclk_i.
// - Fault input trips on falling edge or 16 low samples at /8,/16,/128.
// - Both outputs of a compared pair active together trips a short.
// - Software soft-force input drives its group to high impedance.
// - Oscillator stop report trips high impedance.
// - Interrupt raised for fault-input and output-compare requests.
// - Input 0 drives ch3/4, input 4 drives ch6/7, input 8 drives ch0.
// - Inputs 10 and 11 act only when added as conditions.
// - Six pairs compared: three for ch3/4, three for ch6/7.
// - Forced pins float even when assigned to a non-timer function.
// - Pin select picks the port; forcing applies to the selected port.
// - Software can add further fault inputs to each pin group.
// - Added inputs: ch3/4 4,8,10,11; ch6/7 0,8,10,11; ch0 0,4,10,11.
// - Oscillator-stop forcing holds until cleared; reset restores defaults.
// - Group interrupt pending clears when the status bits are cleared.
`include "oshz_defs.svh"
module oshz_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Fault inputs, active low: 0, 4, 8, 10, 11
  input wire logic fault_input_0_n_i,
  input wire logic fault_input_4_n_i,
  input wire logic fault_input_8_n_i,
  input wire logic fault_input_10_n_i,
  input wire logic fault_input_11_n_i,
  // Clock generator oscillator-stop report
  input wire logic osc_stop_i,
  // Software control
  input wire oshz_pkg::oshz_ctrl_type ctrl_i,
  input wire logic [1:0] pin_sel0_i,
  input wire logic pin_sel3_i,
  input wire logic [1:0] pin_sel4_i,
  // Timer outputs: compared pair levels and active levels
  input wire oshz_pkg::oshz_pairs_type pairs_i,
  input wire logic [5:0] active_hi_i,
  input wire oshz_pkg::oshz_pairs_type pairs_oe_n_i,
  // Status
  output logic [4:0] in_flag_o,
  output logic [1:0] cmp_flag_o,
  output logic [2:0] osc_hiz_o,
  output logic [2:0] hiz_o,
  output logic group_interrupt_line_o,
  // Port pins: each pair output lands on one of two ports
  output oshz_pkg::oshz_pairs_type port_a_o,
  output oshz_pkg::oshz_pairs_type port_b_o,
  output oshz_pkg::oshz_pairs_type port_a_oe_n_o,
  output oshz_pkg::oshz_pairs_type port_b_oe_n_o
);
  // ==========================================================
  // Fault detectors
  oshz_pkg::oshz_state_type st, next_st;
  logic [4:0] fault_n;
  logic [4:0] det_flag;
  logic [5:0] short_pair;
  logic [2:0] grp_fault;
  logic [11:0] pin_lvl, pin_oe_n, pin_a, pin_b, pin_a_oe, pin_b_oe;
  logic [11:0] pin_hiz, pin_sel;
  assign fault_n = {fault_input_11_n_i, fault_input_10_n_i, fault_input_8_n_i,
    fault_input_4_n_i, fault_input_0_n_i};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_det
      oshz_fault_det u_det (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .fault_n_i(fault_n[gi]),
        .mode_i(ctrl_i.mode[gi]),
        .clr_i(ctrl_i.clr_in[gi]),
        .flag_o(det_flag[gi])
      );
    end
  endgenerate
  // ==========================================================
  // Request combining
  always_comb
  begin
    next_st = st;
    next_st.in_flag = det_flag;
    // Short: both sides at their active level together
    for (int i = 0; i < 6; i++)
    begin
      short_pair[i] = (pairs_i.hi[i] == active_hi_i[i]) && (pairs_i.lo[i] == active_hi_i[i]);
    end
    next_st.cmp_flag[0] = (|short_pair[2:0] && ctrl_i.cmp_en[0])
      || (st.cmp_flag[0] && !ctrl_i.clr_cmp[0]);
    next_st.cmp_flag[1] = (|short_pair[5:3] && ctrl_i.cmp_en[1])
      || (st.cmp_flag[1] && !ctrl_i.clr_cmp[1]);
    // Default routing plus software-added inputs
    grp_fault[`OSHZ_GRP34] = det_flag[`OSHZ_IN0]
      || (det_flag[`OSHZ_IN4] && ctrl_i.add_in4[`OSHZ_GRP34])
      || (det_flag[`OSHZ_IN8] && ctrl_i.add_in8[`OSHZ_GRP34])
      || (det_flag[`OSHZ_IN10] && ctrl_i.add_in10[`OSHZ_GRP34])
      || (det_flag[`OSHZ_IN11] && ctrl_i.add_in11[`OSHZ_GRP34]);
    grp_fault[`OSHZ_GRP67] = det_flag[`OSHZ_IN4]
      || (det_flag[`OSHZ_IN0] && ctrl_i.add_in0[`OSHZ_GRP67])
      || (det_flag[`OSHZ_IN8] && ctrl_i.add_in8[`OSHZ_GRP67])
      || (det_flag[`OSHZ_IN10] && ctrl_i.add_in10[`OSHZ_GRP67])
      || (det_flag[`OSHZ_IN11] && ctrl_i.add_in11[`OSHZ_GRP67]);
    grp_fault[`OSHZ_GRP0] = det_flag[`OSHZ_IN8]
      || (det_flag[`OSHZ_IN0] && ctrl_i.add_in0[`OSHZ_GRP0])
      || (det_flag[`OSHZ_IN4] && ctrl_i.add_in4[`OSHZ_GRP0])
      || (det_flag[`OSHZ_IN10] && ctrl_i.add_in10[`OSHZ_GRP0])
      || (det_flag[`OSHZ_IN11] && ctrl_i.add_in11[`OSHZ_GRP0]);
    // Oscillator stop latches per group; only software or reset undoes it
    for (int g = 0; g < 3; g++)
    begin
      next_st.osc_hiz[g] = (osc_stop_i && ctrl_i.osc_en[g])
        || (st.osc_hiz[g] && !ctrl_i.clr_osc[g]);
    end
    next_st.hiz[`OSHZ_GRP34] = grp_fault[`OSHZ_GRP34] || st.cmp_flag[0];
    next_st.hiz[`OSHZ_GRP67] = grp_fault[`OSHZ_GRP67] || st.cmp_flag[1];
    next_st.hiz[`OSHZ_GRP0] = grp_fault[`OSHZ_GRP0];
    next_st.hiz = next_st.hiz | ctrl_i.soft_hiz | st.osc_hiz;
    next_st.pin_sel0 = pin_sel0_i;
    next_st.pin_sel3 = pin_sel3_i;
    next_st.pin_sel4 = pin_sel4_i;
    // Level of pending statuses; drops as soon as software clears them
    next_st.irq = |det_flag || |next_st.cmp_flag;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
  // ==========================================================
  // Pin gating
  // Pairs 0..2 belong to ch3/4; ch0 shares pin gating via pin_sel0
  assign pin_lvl = {pairs_i.hi, pairs_i.lo};
  assign pin_oe_n = {pairs_oe_n_i.hi, pairs_oe_n_i.lo};
  always_comb
  begin
    for (int p = 0; p < 12; p++)
    begin
      pin_hiz[p] = (p % 6 < 3) ? st.hiz[`OSHZ_GRP34] : st.hiz[`OSHZ_GRP67];
    end
    // Channel 0 signals are muxed onto pair 0 ports; channel 0 forcing applies
    pin_hiz[0] = st.hiz[`OSHZ_GRP34] || st.hiz[`OSHZ_GRP0];
    pin_hiz[6] = st.hiz[`OSHZ_GRP34] || st.hiz[`OSHZ_GRP0];
    pin_sel = '0;
    pin_sel[0] = st.pin_sel0[0] || st.pin_sel3;
    pin_sel[6] = st.pin_sel0[1] || st.pin_sel3;
    pin_sel[1] = st.pin_sel4[0];
    pin_sel[7] = st.pin_sel4[0];
    pin_sel[2] = st.pin_sel4[1];
    pin_sel[8] = st.pin_sel4[1];
  end
  generate
    for (gi = 0; gi < 12; gi++)
    begin : g_pin
      oshz_pin_gate u_gate (
        .out_i(pin_lvl[gi]),
        .oe_n_i(pin_oe_n[gi]),
        .sel_i(pin_sel[gi]),
        .hiz_i(pin_hiz[gi]),
        .pin_o({pin_b[gi], pin_a[gi]}),
        .pin_oe_n_o({pin_b_oe[gi], pin_a_oe[gi]})
      );
    end
  endgenerate
  // Registered port drive keeps every output straight from a flop
  oshz_pkg::oshz_pairs_type pa, pb, pae, pbe;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pa <= '0;
      pb <= '0;
      pae <= '1;
      pbe <= '1;
    end
    else
    begin
      pa <= pin_a;
      pb <= pin_b;
      pae <= pin_a_oe;
      pbe <= pin_b_oe;
    end
  end
  assign port_a_o = pa;
  assign port_b_o = pb;
  assign port_a_oe_n_o = pae;
  assign port_b_oe_n_o = pbe;
  assign in_flag_o = st.in_flag;
  assign cmp_flag_o = st.cmp_flag;
  assign osc_hiz_o = st.osc_hiz;
  assign hiz_o = st.hiz;
  assign group_interrupt_line_o = st.irq;
endmodule // oshz_top

/* File: dv/oshz_monitor.sv */
// Port assertions for the output shutdown controller
module oshz_monitor (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Watched inputs
  input wire logic fault_input_0_n_i,
  input wire logic osc_stop_i,
  input wire oshz_pkg::oshz_ctrl_type ctrl_i,
  input wire oshz_pkg::oshz_pairs_type pairs_i,
  input wire logic [5:0] active_hi_i,
  input wire logic [1:0] pin_sel4_i,
  input wire oshz_pkg::oshz_pairs_type pairs_oe_n_i,
  // Watched outputs
  input wire logic [4:0] in_flag_o,
  input wire logic [1:0] cmp_flag_o,
  input wire logic [2:0] osc_hiz_o,
  input wire logic [2:0] hiz_o,
  input wire logic group_interrupt_line_o,
  input wire oshz_pkg::oshz_pairs_type port_a_o,
  input wire oshz_pkg::oshz_pairs_type port_b_o,
  input wire oshz_pkg::oshz_pairs_type port_a_oe_n_o,
  input wire oshz_pkg::oshz_pairs_type port_b_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // Assertions
  irq_level_a: assert property (group_interrupt_line_o == (|in_flag_o || |cmp_flag_o))
    else $error("irq line disagrees with flags");
  edge_trip_a: assert property ($fell(fault_input_0_n_i) && ctrl_i.mode[0] == 2'h0
    |-> ##[1:4] in_flag_o[0]) else $error("edge fault not flagged");
  // A clear takes two edges to reach the status output
  flag_hold_a: assert property (in_flag_o[0] && !ctrl_i.clr_in[0]
    && !$past(ctrl_i.clr_in[0]) |=> in_flag_o[0]) else $error("flag dropped without clear");
  flag_force_a: assert property (in_flag_o[0] |-> hiz_o[0])
    else $error("flag did not force group");
  port_lvl_a: assert property ($past(rst_n_i) |-> port_a_o == $past(pairs_i)
    && port_b_o == $past(pairs_i)) else $error("port level lost");
  sel_route_a: assert property ($past(rst_n_i, 2) && !$past(hiz_o[0])
    && !$past(pairs_oe_n_i.lo[1]) |-> port_a_oe_n_o.lo[1] == $past(pin_sel4_i[0], 2)
    && port_b_oe_n_o.lo[1] == !$past(pin_sel4_i[0], 2)) else $error("wrong port selected");
  port_float_a: assert property (hiz_o[0] |=> &{port_a_oe_n_o.hi[2:0],
    port_a_oe_n_o.lo[2:0], port_b_oe_n_o.hi[2:0], port_b_oe_n_o.lo[2:0]})
    else $error("forced pin still driven");
  short_trip_a: assert property (ctrl_i.cmp_en[0] && pairs_i.hi[1] == active_hi_i[1]
    && pairs_i.lo[1] == active_hi_i[1] |=> cmp_flag_o[0]) else $error("short missed");
  soft_force_a: assert property (ctrl_i.soft_hiz[1] |=> hiz_o[1])
    else $error("soft force ignored");
  osc_trip_a: assert property (osc_stop_i && ctrl_i.osc_en[2] |-> ##[1:2] osc_hiz_o[2])
    else $error("osc stop missed");
  osc_hold_a: assert property (osc_hiz_o[2] && !ctrl_i.clr_osc[2] |=> osc_hiz_o[2])
    else $error("osc force dropped");
  cover property (cmp_flag_o[0]);
  cover property (osc_hiz_o[2]);
  cover property (hiz_o[1]);
endmodule // oshz_monitor

bind oshz_top oshz_monitor i_mon (.mclk_i, .rst_n_i, .fault_input_0_n_i, .osc_stop_i, .ctrl_i,
  .pairs_i, .active_hi_i, .pin_sel4_i, .pairs_oe_n_i, .in_flag_o, .cmp_flag_o, .osc_hiz_o,
  .hiz_o, .group_interrupt_line_o, .port_a_o, .port_b_o, .port_a_oe_n_o, .port_b_oe_n_o);

/* File: dv/oshz_timer_model.sv */
// Timer output model: complementary pairs, shorts only on command
module oshz_timer_model (
  // Clock
  input wire logic mclk_i,
  // Commanded shorts and active levels, one per pair
  input wire logic [5:0] short_i,
  input wire logic [5:0] act_i,
  // Timer outputs
  output oshz_pkg::oshz_pairs_type pairs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] phase = 6'h15;
  // Toggling keeps pairs complementary yet never static
  always @(posedge mclk_i) phase <= ~phase;
  // Pins match their active level together only while a short is commanded
  assign pairs_o.hi = (phase | short_i) ~^ act_i;
  assign pairs_o.lo = (~phase | short_i) ~^ act_i;
endmodule // oshz_timer_model

/* File: dv/testbench.sv */
// Self-checking bench for the output shutdown controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] flt_n = 5'h1f;
  logic osc_stop = 1'b0;
  oshz_pkg::oshz_ctrl_type ctrl = '0;
  logic [5:0] short_req = 6'h00;
  logic [4:0] sel = 5'h00;
  oshz_pkg::oshz_pairs_type pairs, pa, pb, pa_oe_n, pb_oe_n;
  oshz_pkg::oshz_pairs_type pairs_oe_n = '0;
  logic [5:0] act_hi = 6'h3f;
  logic [4:0] in_flag;
  logic [1:0] cmp_flag;
  logic [2:0] osc_hiz, hiz;
  logic irq;
  logic [12:0] exp_q[$];
  logic [12:0] stat;
  logic [12:0] last = 13'h0000;
  logic [12:0] want;
  int miscompares = 0;
  int samples_checked = 0;
  int divs[3] = '{8, 16, 128};
  always #5 mclk_i = ~mclk_i;
  assign stat = {in_flag, cmp_flag, osc_hiz, hiz};
  oshz_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fault_input_0_n_i(flt_n[0]),
    .fault_input_4_n_i(flt_n[1]), .fault_input_8_n_i(flt_n[2]), .fault_input_10_n_i(flt_n[3]),
    .fault_input_11_n_i(flt_n[4]), .osc_stop_i(osc_stop), .ctrl_i(ctrl), .pin_sel0_i(sel[1:0]),
    .pin_sel3_i(sel[2]), .pin_sel4_i(sel[4:3]), .pairs_i(pairs), .active_hi_i(act_hi),
    .pairs_oe_n_i(pairs_oe_n), .in_flag_o(in_flag), .cmp_flag_o(cmp_flag), .osc_hiz_o(osc_hiz),
    .hiz_o(hiz), .group_interrupt_line_o(irq), .port_a_o(pa), .port_b_o(pb),
    .port_a_oe_n_o(pa_oe_n), .port_b_oe_n_o(pb_oe_n));
  oshz_timer_model i_tmr (.mclk_i(mclk_i), .short_i(short_req), .act_i(act_hi),
    .pairs_o(pairs));
  // ==========================================
  // Watcher: each status change takes the oldest note
  always @(negedge mclk_i)
  begin
    if (rst_n_i && stat !== last)
    begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : ~stat;
      `CHK(stat, want)
      `CHK(irq, |want[12:6])
    end
    last = stat;
  end
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic fall(input int k, input int len);
    flt_n[k] = 1'b0;
    tick(len);
    flt_n[k] = 1'b1;
    tick(6);
  endtask
  // Flag and the groups it forced drop together, two edges after the clear
  task automatic clear_in(input int k);
    exp_q.push_back(13'h0000);
    ctrl.clr_in[k] = 1'b1;
    tick(1);
    ctrl.clr_in[k] = 1'b0;
    tick(4);
  endtask
  // Flag and its group forces rise on the same edge
  task automatic trip(input int k, input logic [2:0] hmask, input int len);
    {sel, act_hi} = 11'($urandom);
    pairs_oe_n = 12'($urandom & $urandom);
    exp_q.push_back((13'h0100 << k) | 13'(hmask));
    fall(k, len);
    clear_in(k);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h8a18));
    sel = 5'($urandom);
    tick(10);
    rst_n_i = 1'b1;
    tick(2);
    for (int k = 0; k < 3; k++)
      trip(k, 3'(1 << k), 1 + $urandom % 4);
    ctrl.add_in10[2] = 1'b1;
    trip(3, 3'h4, 2);
    trip(4, 3'h0, 2);
    ctrl.add_in0 = 3'h2;
    ctrl.add_in4 = 3'h4;
    ctrl.add_in8 = 3'h1;
    ctrl.add_in11 = 3'h3;
    trip(0, 3'h3, 2);
    trip(1, 3'h6, 2);
    trip(2, 3'h5, 2);
    trip(4, 3'h3, 2);
    ctrl = '0;
    for (int m = 1; m < 4; m++)
    begin
      ctrl.mode[1] = 2'(m);
      fall(1, 14 * divs[m - 1]);
      trip(1, 3'h2, 17 * divs[m - 1] + 8);
    end
    for (int g = 0; g < 2; g++)
    begin
      ctrl.cmp_en = 3'(1 << g);
      exp_q.push_back(13'h0040 << g);
      exp_q.push_back((13'h0040 << g) | (13'h0001 << g));
      short_req[3 * g + 1] = 1'b1;
      tick(1);
      short_req = 6'h08 >> (3 * g); // disabled group sees this one
      ctrl.cmp_en = 3'(1 << g);
      tick(1);
      short_req = 6'h00;
      tick(5);
      exp_q.push_back(13'h0001 << g);
      exp_q.push_back(13'h0000);
      ctrl.clr_cmp[g] = 1'b1;
      tick(1);
      ctrl.clr_cmp = 2'h0;
      tick(4);
    end
    exp_q.push_back(13'h0002);
    ctrl.soft_hiz[1] = 1'b1;
    tick(3);
    exp_q.push_back(13'h0000);
    ctrl.soft_hiz[1] = 1'b0;
    tick(3);
    ctrl.osc_en = 3'h4;
    exp_q.push_back(13'h0020);
    exp_q.push_back(13'h0024);
    osc_stop = 1'b1;
    tick(3);
    osc_stop = 1'b0;
    tick(6);
    exp_q.push_back(13'h0004);
    exp_q.push_back(13'h0000);
    ctrl.clr_osc[2] = 1'b1;
    tick(1);
    ctrl.clr_osc[2] = 1'b0;
    tick(4);
    `CHK(exp_q.size(), 0)
    stop_test();
  end
  initial
  begin
    #200us;
    miscompares++;
    stop_test();
  end
endmodule // testbench
